//--- logic/idma_defines.svh
// constants shared by the host-port glue and the memory-port device
// Summary of operation
// - 16-bit shared bus, host starts every transfer
// - pointer: 14-bit address plus memory-type bit
// - host loads pointer with latch plus 15 bits
// - pointer auto-advances after each completed word
// - program word: upper 16, then low 8
// - program pointer advances after second half only
// - two host locations: pointer and data
// - ack ends cycle; start only when ack low
// - latch strobe follows host address bit A1
// - select low when strobe low, A12 low, A13 high
// - data at 0x2000, pointer loads at 0x2002
// - read strobe is inverted read/write line
// - write strobe is read/write OR A2
// - host boot straps: wait for host download
// - restart vector write ends boot, starts core
// - fill program upward, restart vector last
// - every segment starts with a latch cycle
// - data segments may come first or interleave
// - pointer bit 14 set selects data memory
// - memory-type bit zero selects program memory
// - no core interrupt; transfers run independently
`ifndef IDMA_DEFINES_SVH
`define IDMA_DEFINES_SVH
`define PORT_W 16
`define PTR_W 15
`define ADDR_W 14
`define PTR_TYPE_BIT 14
`define PM_W 24
`define PM_LO_W 8
`define HA_LATCH 1
`define HA_WR_GATE 2
`define HA_SEL_LO 12
`define HA_SEL_HI 13
`define DATA_LOC 16'h2000
`define PTR_LOC 16'h2002
`define RESTART_VEC 14'h0000
`define ACK_TIME_NS 30
`define CLK_NS 10
`define ACK_CYC ((`ACK_TIME_NS + `CLK_NS - 1) / `CLK_NS)
`define STRAP_CYC 2'h2
`define OFS_HADDR 8'h00
`define OFS_WDATA 8'h04
`define OFS_CMD 8'h08
`define OFS_STATUS 8'h0c
`define OFS_RDATA 8'h10
`define CMD_READ_BIT 0
`define ST_BUSY_BIT 0
`define ST_ACK_BIT 1
`define ST_DONE_BIT 2
`endif

//--- logic/idma_pkg.sv
// types shared by both ends of the memory port
package idma_pkg;
    typedef enum logic [1:0] {D_IDLE, D_BUSY, D_DONE} dev_state_e;
    typedef enum logic [2:0] {
        H_IDLE, H_CHECK, H_SETUP, H_STROBE, H_TERM, H_RELEASE
    } host_state_e;
endpackage

//--- logic/idma_if.sv
// wires between host glue and memory-port device
`timescale 1ns/1ps
`include "idma_defines.svh"
interface idma_if;
    logic [`PORT_W-1:0] host_ad_o;
    logic host_ad_oe;
    logic [`PORT_W-1:0] dev_ad_o;
    logic dev_ad_oe;
    logic [`PORT_W-1:0] muxed_addr_data_bus;
    logic port_select_n;
    logic port_read_n;
    logic port_write_n;
    logic port_latch;
    logic port_ack_n;
    // shared bus level; undriven bus floats high as if pulled up
    assign muxed_addr_data_bus = host_ad_oe ? host_ad_o :
                                 dev_ad_oe ? dev_ad_o : '1;
    modport host (
        output host_ad_o, host_ad_oe, port_select_n, port_read_n,
        output port_write_n, port_latch,
        input muxed_addr_data_bus, port_ack_n
    );
    modport dev (
        output dev_ad_o, dev_ad_oe, port_ack_n,
        input muxed_addr_data_bus, port_select_n, port_read_n,
        input port_write_n, port_latch
    );
endinterface // idma_if

//--- logic/idma_device.sv
// memory-port device: pointer, program/data memories, host boot
`timescale 1ns/1ps
`include "idma_defines.svh"
module idma_device #(
    parameter int MEM_AW = 8,
    parameter int ACK_CYC = `ACK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    idma_if.dev port,
    input wire logic memory_map_strap,
    input wire logic boot_source_strap,
    output logic core_run,
    output logic boot_wait,
    output logic [`PTR_W-1:0] pointer_value
);
    // all pins re-timed together: two cycles of delay, no skew
    localparam int SYNC_W = `PORT_W + 6;
    typedef struct packed {
        // access sequencing
        idma_pkg::dev_state_e state;
        logic [3:0] cnt;
        // two-stage pin synchroniser
        logic [SYNC_W-1:0] sync1;
        logic [SYNC_W-1:0] sync2;
        // pointer and upper part of a program word
        logic [`PTR_W-1:0] ptr;
        logic half;
        logic [`PORT_W-1:0] hi;
        // answer to the host
        logic [`PORT_W-1:0] rd_data;
        logic drv;
        logic ack_n;
        // strap capture and core release
        logic [1:0] strap_cnt;
        logic boot_host;
        logic run;
        logic boot_wait;
    } dev_s;

    dev_s s_r;
    dev_s s_nxt;
    logic [`PM_W-1:0] pm_mem [2**MEM_AW];
    logic [`PORT_W-1:0] dm_mem [2**MEM_AW];
    logic pm_wr;
    logic dm_wr;
    // synchronised host strobes, active high inside the device
    logic sel;
    logic rd;
    logic wr;
    logic lat;
    // synchronised straps
    logic memory_map_strap_s;
    logic boot_source_strap_s;
    // helpers for the access sequencer
    logic acc_end;
    logic host_boot;
    logic restart_hit;
    logic [`PORT_W-1:0] bus;
    logic [MEM_AW-1:0] idx;
    logic [`PTR_W-1:0] ptr_inc;

    // synchronised pin views, second stage only
    assign sel = ~s_r.sync2[`PORT_W+3];
    assign rd = ~s_r.sync2[`PORT_W+2];
    assign wr = ~s_r.sync2[`PORT_W+1];
    assign lat = s_r.sync2[`PORT_W];
    assign bus = s_r.sync2[`PORT_W-1:0];
    assign memory_map_strap_s = s_r.sync2[`PORT_W+5];
    assign boot_source_strap_s = s_r.sync2[`PORT_W+4];
    assign idx = s_r.ptr[MEM_AW-1:0];
    // address wraps inside its space, type bit kept
    assign ptr_inc = {s_r.ptr[`PTR_TYPE_BIT],
                      s_r.ptr[`ADDR_W-1:0] + `ADDR_W'(1)};
    // access takes effect on the last busy cycle
    assign acc_end = (s_r.state == idma_pkg::D_BUSY) &&
                     (s_r.cnt == 4'(ACK_CYC - 1));
    // memory map strap low and boot strap high: host loads us
    assign host_boot = ~memory_map_strap_s & boot_source_strap_s;
    // second half of the restart vector ends a host boot
    assign restart_hit = wr && s_r.half && s_r.boot_host && !s_r.run &&
                         s_r.ptr[`ADDR_W-1:0] == `RESTART_VEC;

    ////////////////////////////////////////////////////////////////////
    // next state; core never touches this path, so no interrupt
    always_comb begin
        s_nxt = s_r;
        pm_wr = 1'b0;
        dm_wr = 1'b0;
        s_nxt.sync1 = {memory_map_strap, boot_source_strap,
                       port.port_select_n, port.port_read_n,
                       port.port_write_n, port.port_latch,
                       port.muxed_addr_data_bus};
        s_nxt.sync2 = s_r.sync1;
        // straps caught once, after they cleared the synchroniser
        if (s_r.strap_cnt != 2'h3) begin
            s_nxt.strap_cnt = s_r.strap_cnt + 2'h1;
        end
        // any other strap setting lets the core run at once
        if (s_r.strap_cnt == `STRAP_CYC) begin
            s_nxt.boot_host = host_boot;
            s_nxt.run = ~host_boot;
            s_nxt.boot_wait = host_boot;
        end
        case (s_r.state)
            idma_pkg::D_IDLE: begin
                // ack low tells the host the port is ready
                s_nxt.ack_n = 1'b0;
                s_nxt.drv = 1'b0;
                // only a host strobe opens an access
                if (sel && (rd || wr)) begin
                    s_nxt.state = idma_pkg::D_BUSY;
                    s_nxt.cnt = 4'h0;
                    s_nxt.ack_n = 1'b1;
                end
            end
            idma_pkg::D_BUSY: begin
                // strobes and bus are used only after a full busy
                // time, so a slow host has settled its bus by then
                s_nxt.cnt = s_r.cnt + 4'h1;
                if (acc_end) begin
                    s_nxt.state = idma_pkg::D_DONE;
                    s_nxt.ack_n = 1'b0;
                    // latch cycle: write loads the pointer, read shows it
                    if (lat) begin
                        if (wr) begin
                            s_nxt.ptr = bus[`PTR_W-1:0];
                            s_nxt.half = 1'b0;
                        end else begin
                            s_nxt.drv = 1'b1;
                            s_nxt.rd_data = {1'b0, s_r.ptr};
                        end
                    end else if (!s_r.ptr[`PTR_TYPE_BIT]) begin
                        // program word split over two accesses
                        if (rd) begin
                            s_nxt.drv = 1'b1;
                            s_nxt.rd_data = s_r.half ?
                                {8'h00, pm_mem[idx][`PM_LO_W-1:0]} :
                                pm_mem[idx][`PM_W-1:`PM_LO_W];
                        end else begin
                            s_nxt.hi = s_r.half ? s_r.hi : bus;
                            pm_wr = s_r.half;
                        end
                        s_nxt.half = ~s_r.half;
                        if (s_r.half) begin
                            s_nxt.ptr = ptr_inc;
                        end
                        // limitation: reading the restart word back
                        // never ends the boot, only a host write does
                        if (restart_hit) begin
                            s_nxt.run = 1'b1;
                            s_nxt.boot_wait = 1'b0;
                        end
                    end else begin
                        // data memory: one whole word per access
                        if (rd) begin
                            s_nxt.drv = 1'b1;
                            s_nxt.rd_data = dm_mem[idx];
                        end else begin
                            dm_wr = 1'b1;
                        end
                        s_nxt.ptr = ptr_inc;
                    end
                end
            end
            idma_pkg::D_DONE: begin
                // read data held until the host lets go; ack stays
                // low here, so the host may already queue its next cycle
                if (!sel || !(rd || wr)) begin
                    s_nxt.state = idma_pkg::D_IDLE;
                    s_nxt.drv = 1'b0;
                end
            end
            default: s_nxt.state = idma_pkg::D_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register; pins idle high so reset them that way
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.sync1 <= '1;
            s_r.sync2 <= '1;
            s_r.ack_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // program words, no reset: contents come from the host download;
    // pointer bits above MEM_AW alias onto the same words
    always_ff @(posedge pclk) begin
        if (pm_wr) begin
            pm_mem[idx] <= {s_r.hi, bus[`PM_LO_W-1:0]};
        end
    end

    // data words, same indexing as program words
    always_ff @(posedge pclk) begin
        if (dm_wr) begin
            dm_mem[idx] <= bus;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs straight from state flops; read data reaches the bus
    // only while the device owns it
    assign port.dev_ad_o = s_r.rd_data;
    assign port.dev_ad_oe = s_r.drv;
    assign port.port_ack_n = s_r.ack_n;
    assign core_run = s_r.run;
    assign boot_wait = s_r.boot_wait;
    assign pointer_value = s_r.ptr;
endmodule // idma_device

//--- logic/idma_host.sv
// host end: apb command registers, host bus cycles, strobe glue
`timescale 1ns/1ps
`include "idma_defines.svh"
module idma_host (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    idma_if.host port
);
    typedef struct packed {
        idma_pkg::host_state_e state;
        logic [`PORT_W-1:0] haddr;
        logic [`PORT_W-1:0] wdata;
        logic [`PORT_W-1:0] rdata;
        logic cmd_read;
        logic [`PORT_W-1:0] baddr;
        logic rw;
        logic ds_n;
        logic oe;
        logic busy;
        logic done;
        logic ack_s1;
        logic ack_s2;
        logic [`PORT_W-1:0] bus_s1;
        logic [`PORT_W-1:0] bus_s2;
        logic [31:0] prdata;
        logic pready;
    } host_s;

    host_s s_r;
    host_s s_nxt;
    logic wr_acc;
    logic start;

    assign wr_acc = psel & penable & pwrite & s_r.pready;
    // a command while busy is dropped
    assign start = wr_acc && paddr == `OFS_CMD && !s_r.busy;

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        s_nxt = s_r;
        s_nxt.pready = 1'b1;
        s_nxt.ack_s1 = port.port_ack_n;
        s_nxt.ack_s2 = s_r.ack_s1;
        s_nxt.bus_s1 = port.muxed_addr_data_bus;
        s_nxt.bus_s2 = s_r.bus_s1;
        // read data prepared in setup, valid through access
        if (psel && !penable && !pwrite) begin
            case (paddr)
                `OFS_HADDR: s_nxt.prdata = {16'h0000, s_r.haddr};
                `OFS_WDATA: s_nxt.prdata = {16'h0000, s_r.wdata};
                `OFS_STATUS: begin
                    s_nxt.prdata = 32'h0000_0000;
                    s_nxt.prdata[`ST_BUSY_BIT] = s_r.busy;
                    s_nxt.prdata[`ST_ACK_BIT] = s_r.ack_s2;
                    s_nxt.prdata[`ST_DONE_BIT] = s_r.done;
                end
                `OFS_RDATA: s_nxt.prdata = {16'h0000, s_r.rdata};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
        if (wr_acc && paddr == `OFS_HADDR) begin
            // software picks data or pointer location
            s_nxt.haddr = pwdata[`PORT_W-1:0];
        end
        if (wr_acc && paddr == `OFS_WDATA) begin
            s_nxt.wdata = pwdata[`PORT_W-1:0];
        end
        // segment order and restart-vector-last are left to software
        if (start) begin
            s_nxt.cmd_read = pwdata[`CMD_READ_BIT];
            s_nxt.busy = 1'b1;
            s_nxt.done = 1'b0;
            s_nxt.state = idma_pkg::H_CHECK;
        end
        case (s_r.state)
            idma_pkg::H_IDLE: begin
                s_nxt.ds_n = 1'b1;
                s_nxt.oe = 1'b0;
            end
            idma_pkg::H_CHECK: begin
                // start only while the ack flag reads low
                if (!s_r.ack_s2) begin
                    s_nxt.state = idma_pkg::H_SETUP;
                    s_nxt.baddr = s_r.haddr;
                    s_nxt.rw = s_r.cmd_read;
                    s_nxt.oe = ~s_r.cmd_read;
                end
            end
            idma_pkg::H_SETUP: begin
                // address and data settle a cycle before the strobe
                s_nxt.state = idma_pkg::H_STROBE;
                s_nxt.ds_n = 1'b0;
            end
            idma_pkg::H_STROBE: begin
                if (s_r.ack_s2) begin
                    s_nxt.state = idma_pkg::H_TERM;
                end
            end
            idma_pkg::H_TERM: begin
                // ack low terminates the bus cycle
                if (!s_r.ack_s2) begin
                    s_nxt.state = idma_pkg::H_RELEASE;
                    s_nxt.ds_n = 1'b1;
                    if (s_r.rw) begin
                        s_nxt.rdata = s_r.bus_s2;
                    end
                end
            end
            idma_pkg::H_RELEASE: begin
                s_nxt.state = idma_pkg::H_IDLE;
                s_nxt.oe = 1'b0;
                s_nxt.rw = 1'b1;
                s_nxt.busy = 1'b0;
                s_nxt.done = 1'b1;
            end
            default: s_nxt.state = idma_pkg::H_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
            s_r.haddr <= `DATA_LOC;
            s_r.rw <= 1'b1;
            s_r.ds_n <= 1'b1;
            s_r.ack_s1 <= 1'b1;
            s_r.ack_s2 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // glue: plain gates on registered host bus, no state of its own
    assign port.port_select_n = ~(~s_r.ds_n & ~s_r.baddr[`HA_SEL_LO] &
                                  s_r.baddr[`HA_SEL_HI]);
    assign port.port_latch = s_r.baddr[`HA_LATCH];
    assign port.port_read_n = ~s_r.rw;
    assign port.port_write_n = s_r.rw | s_r.baddr[`HA_WR_GATE];
    // host drives all 16 lines for pointer and data writes
    assign port.host_ad_o = s_r.wdata;
    assign port.host_ad_oe = s_r.oe;
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = 1'b0;
endmodule // idma_host

//--- testbench/idma_port_assertions.sv
// concurrent checks on the wires between host glue and device
`timescale 1ns/1ps
`include "idma_defines.svh"
module idma_port_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic host_ad_oe,
    input wire logic dev_ad_oe,
    input wire logic [`PORT_W-1:0] muxed_addr_data_bus,
    input wire logic port_select_n,
    input wire logic port_read_n,
    input wire logic port_write_n,
    input wire logic port_latch,
    input wire logic port_ack_n
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // bus ownership: one driver, host on writes, device on reads only
    no_contention_a: assert property (!(host_ad_oe && dev_ad_oe))
        else $error("both ends drive the shared bus");
    host_drives_write_a: assert property (
        !port_select_n && !port_write_n |-> host_ad_oe)
        else $error("write strobe without host data");
    host_quiet_read_a: assert property (
        !port_select_n && !port_read_n |-> !host_ad_oe)
        else $error("host drives bus during a read");
    dev_drive_cause_a: assert property (
        $rose(dev_ad_oe) |-> !port_select_n && !port_read_n)
        else $error("device drives bus unasked");
    // strobes: read and write never low together
    strobe_excl_a: assert property (!port_write_n |-> port_read_n)
        else $error("read and write strobes both low");
    // bus held still while the host drives a selected cycle
    bus_stable_a: assert property (
        !port_select_n && host_ad_oe && $past(!port_select_n)
        |-> $stable(muxed_addr_data_bus))
        else $error("bus moved during host write");
    ////////////////////////////////////////////////////////////////////////
    // acknowledge handshake; busy time fixed at three cycles
    ack_cause_a: assert property ($rose(port_ack_n) |-> !port_select_n)
        else $error("device busy without select");
    ack_busy_len_a: assert property (
        $rose(port_ack_n) |-> port_ack_n[*3] ##1 !port_ack_n)
        else $error("acknowledge busy time wrong");
    start_on_ready_a: assert property (
        $fell(port_select_n) |-> !port_ack_n)
        else $error("cycle started while device busy");
    hold_while_busy_a: assert property (
        !port_select_n && port_ack_n |=> !port_select_n)
        else $error("select dropped before acknowledge");
    cycle_ends_a: assert property (
        $fell(port_select_n) |-> ##[1:20] $rose(port_select_n))
        else $error("host cycle never ends");
    // main traffic kinds
    cov_latch: cover property (!port_select_n && port_latch && !port_write_n);
    cov_write: cover property (!port_select_n && !port_latch && !port_write_n);
    cov_read: cover property (!port_select_n && !port_read_n && dev_ad_oe);
endmodule // idma_port_assertions

//--- testbench/host_dma_port_glue_bench.sv
// self-checking bench: apb host glue joined to the memory-port device
`timescale 1ns/1ps
`include "idma_defines.svh"
module host_dma_port_glue_bench;
    logic pclk;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic memory_map_strap = 1'b0;
    logic boot_source_strap = 1'b1;
    logic core_run;
    logic boot_wait;
    logic [14:0] ptr_value;
    int sel_cnt = 0;
    logic [2:0] obs = 3'h0;
    logic [15:0] bus_seen = 16'h0000;
    int err_count = 0;
    int checked = 0;
    int cycles = 0;
    idma_if link();
    idma_host u_idma_host (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port(link));
    idma_device u_idma_device (.pclk(pclk), .presetn(presetn), .port(link),
        .memory_map_strap(memory_map_strap),
        .boot_source_strap(boot_source_strap), .core_run(core_run),
        .boot_wait(boot_wait), .pointer_value(ptr_value));
    idma_port_assertions u_chk (.pclk(pclk), .presetn(presetn),
        .host_ad_oe(link.host_ad_oe), .dev_ad_oe(link.dev_ad_oe),
        .muxed_addr_data_bus(link.muxed_addr_data_bus),
        .port_select_n(link.port_select_n), .port_read_n(link.port_read_n),
        .port_write_n(link.port_write_n), .port_latch(link.port_latch),
        .port_ack_n(link.port_ack_n));
    ////////////////////////////////////////////////////////////////////////
    // clock and hang guard; ceiling far above the ~600 cycles needed
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            stop_test();
        end
    end
    // strobe levels and written bus value seen while selected
    always @(posedge pclk) begin
        if (link.port_select_n === 1'b0) begin
            sel_cnt <= sel_cnt + 1;
            obs <= {link.port_latch, link.port_write_n, link.port_read_n};
            if (link.port_write_n === 1'b0)
                bus_seen <= link.muxed_addr_data_bus;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (err_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; an idle edge after it keeps drives apart
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait limit here: the cycle ceiling catches a dead slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // one host bus cycle through the command registers
    task automatic host_op(input logic [15:0] a, input logic rd,
                           input logic [15:0] d, output logic [15:0] q);
        logic [31:0] v;
        int n;
        int s0;
        logic [3:0] sx;
        s0 = sel_cnt;
        apb(1'b1, `OFS_HADDR, {16'h0000, a}, v);
        apb(1'b1, `OFS_WDATA, {16'h0000, d}, v);
        apb(1'b1, `OFS_CMD, {31'h0000_0000, rd}, v);
        n = 0;
        do begin
            apb(1'b0, `OFS_STATUS, 32'h0000_0000, v);
            n++;
        end while (v[`ST_BUSY_BIT] !== 1'b0 && n < 100);
        check(v[`ST_DONE_BIT], 1'b1);
        check(v[`ST_ACK_BIT], 1'b0);
        sx = {1'b1, a[1], rd | a[2], ~rd};
        check({sel_cnt != s0, obs}, sx);
        if (!rd)
            check(bus_seen, d);
        apb(1'b0, `OFS_RDATA, 32'h0000_0000, v);
        q = v[15:0];
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        logic [15:0] q;
        host_op(a, 1'b0, d, q);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
        logic [15:0] q;
        host_op(a, 1'b1, 16'h0000, q);
        check(q, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // state after reset with host-boot straps, unmapped read
    task automatic t_reset();
        logic [31:0] v;
        apb(1'b1, 8'h1c, 32'hffff_ffff, v);
        apb(1'b0, `OFS_HADDR, 32'h0000_0000, v);
        check(v, 32'h0000_2000);
        apb(1'b1, `OFS_WDATA, 32'h0000_5a5a, v);
        apb(1'b0, `OFS_WDATA, 32'h0000_0000, v);
        check(v, 32'h0000_5a5a);
        apb(1'b0, 8'h1c, 32'h0000_0000, v);
        check(v, 32'h0000_0000);
        check({core_run, boot_wait, pslverr}, 3'h2);
    endtask
    // program words from 1 upward; odd upper byte on word 1's second half
    task automatic t_pm();
        wr(`PTR_LOC, 16'h0001);
        check(ptr_value, 15'h0001);
        wr(`DATA_LOC, 16'h1234);
        check(ptr_value, 15'h0001);
        wr(`DATA_LOC, 16'hff56);
        check(ptr_value, 15'h0002);
        wr(`DATA_LOC, 16'h789a);
        wr(`DATA_LOC, 16'h00bc);
        check(ptr_value, 15'h0003);
        wr(`PTR_LOC, 16'h0001);
        rd_chk(`DATA_LOC, 16'h1234);
        rd_chk(`DATA_LOC, 16'h0056);
        rd_chk(`DATA_LOC, 16'h789a);
        rd_chk(`DATA_LOC, 16'h00bc);
        check(ptr_value, 15'h0003);
    endtask
    // data segment through the 0x6000 alias, pointer read back
    task automatic t_dm();
        wr(16'h6002, 16'h4010);
        check(ptr_value, 15'h4010);
        wr(16'h6000, 16'hbeef);
        check(ptr_value, 15'h4011);
        wr(16'h6000, 16'hcafe);
        wr(16'h6002, 16'h4010);
        rd_chk(16'h6000, 16'hbeef);
        rd_chk(16'h6000, 16'hcafe);
        rd_chk(`PTR_LOC, 16'h4012);
        check(core_run, 1'b0);
    endtask
    // restart vector last: only its second half starts the core
    task automatic t_boot();
        wr(`PTR_LOC, 16'h0000);
        wr(`DATA_LOC, 16'h0a0b);
        check({core_run, boot_wait}, 2'h1);
        wr(`DATA_LOC, 16'h000c);
        check({core_run, boot_wait}, 2'h2);
        check(ptr_value, 15'h0001);
    endtask
    // second reset mid-run, straps set for a self-starting core
    task automatic t_noboot();
        presetn <= 1'b0;
        memory_map_strap <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        check({core_run, boot_wait}, 2'h2);
        check(ptr_value, 15'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // reset, strap capture settle, then the scenarios
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (5) @(posedge pclk);
        t_reset();
        t_pm();
        t_dm();
        t_boot();
        t_noboot();
        stop_test();
    end
endmodule // host_dma_port_glue_bench
